// File: common/tcq_pkg.sv
/*
 * constants of the time code readback queue: register indices, fields,
 * reset values and sizes.
 * assumes a register port whose byte address is four times the index.
 */
// Function
// - descriptor bits 4..0 carry the producing channel's source selection
// - source field is the stamp source code, not the channel index
// - descriptor bits 7..5 carry a 3-bit status per channel flags selection
// - selections 000..100 pack tag/format/fault/invalid/unlocked as tabled
// - 101 and 110 pack format,tag,unlocked-or-x; 111 leaves bits zero
// - queue status bit 7 sets when the queue exceeds its capacity
// - while overfilled, arriving time codes are discarded, held ones kept
// - overfill mirrors to interrupt bit 7 and the status pin
// - reading a sample clears overfill and the pin overfill indication
// - queue status bits 6..0 give held sample count when not overfilled
// - when overfilled, count field gives lost samples, saturating at 127
// - interrupt bit 5 rises when count goes from zero to nonzero
// - not-empty pin stays asserted while count is nonzero
// - queue holds up to 18 samples with their status
// - interrupt bit 6 rises whenever the queue accepts a sample
// - update strobe latches overfill and count into the register map
// - update advances only if the time code was read since last strobe or no sample is presented
// - advancing overwrites time code, source and status with next sample
// - until a time code read clears overfill no new samples enter; queued ones stay readable
// - 96-bit time code sits in twelve byte registers from the first
// - each channel holds a 3-bit flags selection driving status packing
package tcq_pkg;
    localparam logic [15:0] IDX_UPDATE     = 16'h000F;
    localparam logic [15:0] IDX_QSTATUS    = 16'h0E2D;
    localparam logic [15:0] IDX_DESCRIPTOR = 16'h0E2E;
    localparam logic [15:0] IDX_TCODE_LO   = 16'h0E2F;
    localparam logic [15:0] IDX_TCODE_HI   = 16'h0E3A;
    localparam logic [15:0] IDX_PIN_CFG    = 16'h0E40;
    localparam logic [15:0] IDX_IRQ        = 16'h301C;
    localparam int          UPDATE_BIT     = 0;
    localparam int          OVERFILL_BIT   = 7;
    localparam int          IRQ_NONEMPTY   = 5;
    localparam int          IRQ_NEWSAMPLE  = 6;
    localparam int          IRQ_OVERFILL   = 7;
    localparam int          TCODE_W        = 96;
    localparam int          SRC_W          = 5;
    localparam int          STAT_W         = 3;
    localparam int          SAMPLE_W       = TCODE_W + SRC_W + STAT_W;
    localparam int          DEPTH          = 18;
    localparam int          NUM_CH         = 9;
    localparam logic [6:0]  LOST_MAX       = 7'h7F;
    localparam logic [1:0]  PIN_OFF        = 2'h0;
    localparam logic [1:0]  PIN_OVERFILL   = 2'h1;
    localparam logic [1:0]  PIN_NONEMPTY   = 2'h2;
    localparam logic [1:0]  PIN_CFG_RESET  = 2'h0;
endpackage

// File: hw/time_code_readback_fifo.sv
/*
 * time code readback queue: gathers samples from the stamping channels,
 * presents the head sample in the register map and reports status.
 * assumes channel inputs and status conditions come from logic on
 * core_clk, and a register master that never strobes read and write at once.
 */
`timescale 1ns/1ps
`default_nettype none
module time_code_readback_fifo
    import tcq_pkg::*;
#(
    parameter int CHANNELS = NUM_CH,
    parameter int CAP      = DEPTH
)(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    // stamping channel deliveries
    input  wire logic [CHANNELS-1:0]        ch_valid,
    input  wire logic [CHANNELS*TCODE_W-1:0] ch_time_code,
    input  wire logic [CHANNELS*SRC_W-1:0]  ch_source,
    input  wire logic [CHANNELS*3-1:0]      ch_flags_sel,
    input  wire logic [CHANNELS-1:0]        ch_tag,
    input  wire logic [CHANNELS-1:0]        ch_format,
    // common clock conditions
    input  wire logic                       ref_invalid,
    input  wire logic                       ref_fault,
    input  wire logic                       dpll_unlocked,
    // register port
    input  wire logic [17:0]                reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // status pin
    output logic                            multifunction_status_pin
);
    localparam int PW = $clog2(CAP);
    localparam int CW = $clog2(CAP + 1);

    // status packing per channel flags selection
    function automatic logic [2:0] encode_status(
        input logic [2:0] sel,
        input logic       tag,
        input logic       fmt,
        input logic       inv,
        input logic       flt,
        input logic       unl
    );
        logic [2:0] r;
        r = 3'h0;
        case (sel)
            3'h0: r = {tag, inv, unl};
            3'h1: r = {tag, flt, unl};
            3'h2: r = {fmt, inv, unl};
            3'h3: r = {fmt, flt, unl};
            3'h4: r = {flt, inv, unl};
            3'h5: r = {fmt, tag, unl | inv};
            3'h6: r = {fmt, tag, unl | flt};
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // register index match, word aligned
    function automatic logic hit(input logic [17:0] a, input logic [15:0] i);
        return (a[1:0] == 2'h0) && (a[17:2] == i);
    endfunction

    // pointer wrap
    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        return (p == PW'(CAP - 1)) ? '0 : p + PW'(1);
    endfunction

    logic [SAMPLE_W-1:0] slot_q [CHANNELS];
    logic [CHANNELS-1:0] pend_q;
    logic [SAMPLE_W-1:0] mem_q  [CAP];
    logic [PW-1:0]       wr_ptr_q;
    logic [PW-1:0]       rd_ptr_q;
    logic [CW-1:0]       count_q;
    logic                overfill_q;
    logic [6:0]          lost_q;
    logic                pres_valid_q;
    logic [SAMPLE_W-1:0] pres_q;
    logic [7:0]          qstat_q;
    logic                read_flag_q;
    logic                nonempty_irq_q;
    logic                newsample_irq_q;
    logic                overfill_irq_q;
    logic [1:0]          pin_cfg_q;
    logic [31:0]         rdata_q;
    logic                pin_q;

    // per-channel capture of each delivered sample, packed at arrival
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : gen_slot
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    slot_q[g] <= '0;
                else if (ch_valid[g])
                    slot_q[g] <= {encode_status(ch_flags_sel[g*3 +: 3],
                                   ch_tag[g], ch_format[g], ref_invalid,
                                   ref_fault, dpll_unlocked),
                                  ch_source[g*SRC_W +: SRC_W],
                                  ch_time_code[g*TCODE_W +: TCODE_W]};
            end
        end
    endgenerate

    // lowest pending channel wins
    logic [CHANNELS-1:0] grant;
    logic                any_pend;
    logic [SAMPLE_W-1:0] grant_data;
    always_comb
    begin
        grant      = '0;
        any_pend   = 1'b0;
        grant_data = '0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (pend_q[i] && !any_pend)
            begin
                grant[i]   = 1'b1;
                any_pend   = 1'b1;
                grant_data = slot_q[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_q <= '0;
        else
            pend_q <= (pend_q & ~grant) | ch_valid;
    end

    // register strobes
    logic upd_strobe;
    logic tc_read;
    logic full;
    logic push;
    logic drop;
    logic advance;
    logic pop;
    assign upd_strobe = reg_wr && hit(reg_addr, IDX_UPDATE)
                        && reg_wdata[UPDATE_BIT];
    assign tc_read    = reg_rd && (reg_addr[1:0] == 2'h0)
                        && (reg_addr[17:2] >= IDX_TCODE_LO)
                        && (reg_addr[17:2] <= IDX_TCODE_HI);
    assign full       = (count_q == CW'(CAP));
    assign push       = any_pend && !full && !overfill_q;
    assign drop       = any_pend && (full || overfill_q);
    assign advance    = upd_strobe
                        && (read_flag_q || !pres_valid_q);
    assign pop        = advance && pres_valid_q && (count_q != '0);

    // queue storage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            wr_ptr_q <= '0;
        else if (push)
            wr_ptr_q <= next_ptr(wr_ptr_q);
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_q[wr_ptr_q] <= grant_data;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_ptr_q <= '0;
        else if (pop)
            rd_ptr_q <= next_ptr(rd_ptr_q);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= '0;
        else if (push && !pop)
            count_q <= count_q + CW'(1);
        else if (pop && !push)
            count_q <= count_q - CW'(1);
    end

    // overfill and lost count; a new loss wins over a clearing read
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            overfill_q <= 1'b0;
        else if (drop)
            overfill_q <= 1'b1;
        else if (tc_read)
            overfill_q <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            lost_q <= '0;
        else if (drop)
        begin
            if (!overfill_q)
                lost_q <= 7'h01;
            else if (lost_q != LOST_MAX)
                lost_q <= lost_q + 7'h01;
        end
        else if (tc_read)
            lost_q <= '0;
    end

    // presented sample, replaced only on an advancing update
    logic [PW-1:0] head_ptr;
    logic          head_valid;
    assign head_ptr   = pop ? next_ptr(rd_ptr_q) : rd_ptr_q;
    assign head_valid = pop ? (count_q > CW'(1)) : (count_q != '0);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pres_valid_q <= 1'b0;
            pres_q       <= '0;
        end
        else if (advance)
        begin
            pres_valid_q <= head_valid;
            if (head_valid)
                pres_q <= mem_q[head_ptr];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            read_flag_q <= 1'b0;
        else if (tc_read)
            read_flag_q <= 1'b1;
        else if (upd_strobe)
            read_flag_q <= 1'b0;
    end

    // live status field
    logic [7:0] live_status;
    assign live_status = overfill_q ? {1'b1, lost_q}
                                    : {1'b0, 7'(count_q)};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            qstat_q <= '0;
        else if (upd_strobe)
            qstat_q <= live_status;
    end

    // event bits 5 and 6: write one to clear, a new event wins; bit 7 follows overfill
    logic [CW-1:0] count_prev_q;
    logic          nonempty_evt;
    assign nonempty_evt = (count_prev_q == '0) && (count_q != '0);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_prev_q <= '0;
        else
            count_prev_q <= count_q;
    end

    logic irq_wr;
    assign irq_wr = reg_wr && hit(reg_addr, IDX_IRQ);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            nonempty_irq_q <= 1'b0;
        else if (nonempty_evt)
            nonempty_irq_q <= 1'b1;
        else if (irq_wr && reg_wdata[IRQ_NONEMPTY])
            nonempty_irq_q <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            newsample_irq_q <= 1'b0;
        else if (push)
            newsample_irq_q <= 1'b1;
        else if (irq_wr && reg_wdata[IRQ_NEWSAMPLE])
            newsample_irq_q <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            overfill_irq_q <= 1'b0;
        else
            overfill_irq_q <= overfill_q;
    end

    // status pin configuration and drive
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_cfg_q <= PIN_CFG_RESET;
        else if (reg_wr && hit(reg_addr, IDX_PIN_CFG))
            pin_cfg_q <= reg_wdata[1:0];
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_q <= 1'b0;
        else
        begin
            case (pin_cfg_q)
                PIN_OVERFILL: pin_q <= overfill_q;
                PIN_NONEMPTY: pin_q <= (count_q != '0);
                default:      pin_q <= 1'b0;
            endcase
        end
    end
    assign multifunction_status_pin = pin_q;

    // read data, one cycle after the strobe, zero elsewhere
    logic [15:0] tc_byte;
    assign tc_byte = reg_addr[17:2] - IDX_TCODE_LO;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= '0;
        else if (!reg_rd || (reg_addr[1:0] != 2'h0))
            rdata_q <= '0;
        else if (hit(reg_addr, IDX_QSTATUS))
            rdata_q <= {24'h0, qstat_q};
        else if (hit(reg_addr, IDX_DESCRIPTOR))
            rdata_q <= {24'h0, pres_q[SAMPLE_W-1 -: 8]};
        else if (tc_read)
            rdata_q <= {24'h0, pres_q[tc_byte[3:0]*8 +: 8]};
        else if (hit(reg_addr, IDX_IRQ))
            rdata_q <= {24'h0, overfill_irq_q, newsample_irq_q,
                        nonempty_irq_q, 5'h00};
        else if (hit(reg_addr, IDX_PIN_CFG))
            rdata_q <= {30'h0, pin_cfg_q};
        else
            rdata_q <= '0;
    end
    assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// File: sim/test_time_code_readback_fifo.sv
/*
 * bench of the readback queue: flag table, fill, overflow, drain, reset.
 * assumes the package constants and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module test_time_code_readback_fifo
    import tcq_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [8:0]   ch_valid = '0;
    logic [863:0] ch_time_code = '0;
    logic [44:0]  ch_source = '0;
    logic [26:0]  ch_flags_sel = '0;
    logic [8:0]   ch_tag = '0;
    logic [8:0]   ch_format = '0;
    logic         ref_invalid = 1'b0;
    logic         ref_fault = 1'b0;
    logic         dpll_unlocked = 1'b0;
    logic [17:0]  reg_addr = '0;
    logic [31:0]  reg_wdata = '0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [31:0]  reg_rdata;
    logic         pin;
    int           fail_count = 0;
    int           num_checks = 0;
    int           cycles = 0;
    int           i;
    // {0, selection, tag, format, invalid, fault, unlocked, status}
    logic [11:0]  rows [8] = '{12'h09D, 12'h1A4, 12'h254, 12'h36D,
                               12'h4D4, 12'h565, 12'h6A2, 12'h7F8};

    time_code_readback_fifo DUT (
        .core_clk(core_clk), .rst_n(rst_n), .ch_valid(ch_valid),
        .ch_time_code(ch_time_code), .ch_source(ch_source),
        .ch_flags_sel(ch_flags_sel), .ch_tag(ch_tag),
        .ch_format(ch_format), .ref_invalid(ref_invalid),
        .ref_fault(ref_fault), .dpll_unlocked(dpll_unlocked),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .multifunction_status_pin(pin));

    always #5 core_clk = ~core_clk;

    function automatic logic [17:0] ad(input logic [15:0] idx);
        return {idx, 2'h0};
    endfunction

    function automatic logic [95:0] mk_tc(input int r);
        logic [95:0] t;
        for (int b = 0; b < 12; b++)
            t[b*8+:8] = 8'(r * 16 + b);
        return t;
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= ad(idx);
        reg_wdata <= {24'h0, v};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [17:0] a,
                        input logic [7:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata[7:0]);
    endtask

    task automatic deliver(input logic [8:0] m);
        @(posedge core_clk);
        ch_valid <= m;
        @(posedge core_clk);
        ch_valid <= '0;
        repeat (12) @(posedge core_clk);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        wr(IDX_PIN_CFG, 8'h02);
        for (i = 0; i < 8; i++)
        begin
            ch_flags_sel[i*3+:3] <= rows[i][10:8];
            {ch_tag[i], ch_format[i], ref_invalid, ref_fault,
             dpll_unlocked} <= rows[i][7:3];
            ch_source[i*5+:5] <= 5'(i + 3);
            ch_time_code[i*96+:96] <= mk_tc(i);
            wr(IDX_IRQ, 8'h60);
            deliver(9'h1 << i);
            chk("pin", 8'h01, {7'h0, pin});
            rchk("irq", ad(IDX_IRQ), i == 0 ? 8'h60 : 8'h40);
            wr(IDX_UPDATE, 8'h01);
            rchk("desc", ad(IDX_DESCRIPTOR),
                 {rows[i][2:0], 5'(i + 3)});
            rchk("tcode", ad(IDX_TCODE_LO + 16'(i)), 8'(i * 17));
        end
        wr(IDX_UPDATE, 8'h01);
        repeat (3) @(posedge core_clk);
        chk("pin", 8'h00, {7'h0, pin});
        $display("test flag table done");
        ch_flags_sel <= {9{3'h7}};
        for (i = 0; i < 9; i++)
        begin
            ch_source[i*5+:5] <= 5'(i + 3);
            ch_time_code[i*96+:96] <= mk_tc(i + 8);
        end
        wr(IDX_PIN_CFG, 8'h01);
        wr(IDX_IRQ, 8'h60);
        deliver(9'h1FF);
        deliver(9'h1FF);
        wr(IDX_UPDATE, 8'h01);
        rchk("count", ad(IDX_QSTATUS), 8'h12);
        chk("pin", 8'h00, {7'h0, pin});
        deliver(9'h001);
        deliver(9'h006);
        wr(IDX_UPDATE, 8'h01);
        rchk("lost", ad(IDX_QSTATUS), 8'h83);
        repeat (15) deliver(9'h1FF);
        wr(IDX_UPDATE, 8'h01);
        rchk("lost", ad(IDX_QSTATUS), 8'hFF);
        rchk("irq", ad(IDX_IRQ), 8'hE0);
        chk("pin", 8'h01, {7'h0, pin});
        rchk("pincfg", ad(IDX_PIN_CFG), 8'h01);
        rchk("desc", ad(IDX_DESCRIPTOR), 8'h03);
        wr(IDX_UPDATE, 8'h01);
        rchk("desc", ad(IDX_DESCRIPTOR), 8'h03);
        rchk("tcode", ad(IDX_TCODE_LO), 8'h80);
        repeat (2) @(posedge core_clk);
        chk("pin", 8'h00, {7'h0, pin});
        $display("test overflow done");
        for (i = 0; i < 18; i++)
        begin
            rchk("desc", ad(IDX_DESCRIPTOR), 8'(i % 9 + 3));
            rchk("tcode", ad(IDX_TCODE_LO + 16'(i % 12)),
                 8'((i % 9 + 8) * 16 + i % 12));
            wr(IDX_UPDATE, 8'h01);
        end
        wr(IDX_UPDATE, 8'h01);
        rchk("empty", ad(IDX_QSTATUS), 8'h00);
        $display("test drain done");
        deliver(9'h001);
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk("status", ad(IDX_QSTATUS), 8'h00);
        rchk("irq", ad(IDX_IRQ), 8'h00);
        rchk("unmapped", ad(16'h0001), 8'h00);
        rchk("misaligned", ad(IDX_QSTATUS) + 18'h1, 8'h00);
        chk("pin", 8'h00, {7'h0, pin});
        $display("test reset done");
        wrap_up();
    end
endmodule
`default_nettype wire

// File: sim/time_code_readback_fifo_asserts.sv
/*
 * checker of the readback queue: register read data and status pin.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module tcq_checker
    import tcq_pkg::*;
#(
    parameter int CAP = DEPTH
)(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // register port
    input wire logic [17:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // status pin
    input wire logic        multifunction_status_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // one read strobe at a register index
    sequence s_rd(logic [15:0] idx);
        reg_rd && reg_addr == {idx, 2'h0};
    endsequence

    a_rdata_idle_zero: assert property (
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_upper_bits_zero: assert property (
        reg_rd |=> reg_rdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_misaligned_zero: assert property (
        reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
        else $error("misaligned read returned data");
    a_unmapped_zero: assert property (
        s_rd(16'h0001) |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    a_count_in_cap: assert property (
        s_rd(IDX_QSTATUS) ##1 !reg_rdata[7] |-> reg_rdata[6:0] <= 7'(CAP))
        else $error("held count above capacity");
    a_lost_nonzero: assert property (
        s_rd(IDX_QSTATUS) ##1 reg_rdata[7] |-> reg_rdata[6:0] != 7'h0)
        else $error("overfill with zero lost count");
    a_irq_low_clear: assert property (
        s_rd(IDX_IRQ) |=> reg_rdata[4:0] == 5'h0)
        else $error("unused interrupt bits set");
    a_pin_quiet_reset: assert property (
        $rose(rst_n) |-> !multifunction_status_pin [*2])
        else $error("status pin high right after reset");
endmodule

bind time_code_readback_fifo tcq_checker #(.CAP(CAP)) u_tcq_checker (
    .core_clk                 (core_clk),
    .rst_n                    (rst_n),
    .reg_addr                 (reg_addr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .multifunction_status_pin (multifunction_status_pin)
);
`default_nettype wire
